// ==== hdl/fps_sequencer.sv ====
//
// Behaviour
// R01: erase cut off mid-byte is abandoned, nothing erased, write latch cleared.
// R02: block erase without all three address bytes aborts and clears write latch.
// R03: block erase on protected memory is dropped, back to idle at frame end.
// R04: failed erase verify sets both erase and program error flags.
// R05: opcodes 60h and C7h are the same whole-array erase.
// R06: host sets write latch with write enable before chip erase.
// R07: chip erase refused if block protect field or block locks protect anything.
// R08: chip erase is opcode only; erase starts when chip select rises.
// R09: busy reads set during chip erase; write latch cleared before it ends.
// R10: suspend opcode is ignored while a chip erase runs.
// R11: program frame is opcode, 24-bit address, data bytes, all msb first.
// R12: one to 256 bytes; bytes never received stay erased.
// R13: program starts at frame end; single byte uses the shorter time.
// R14: host sets write latch with write enable before program.
// R15: program cut mid-byte aborts, writes nothing, clears write latch.
// R16: program on protected memory is dropped, back to idle at frame end.
// R17: data past page end wraps to page start; others untouched.
// R18: beyond 256 data bytes only the last 256 are kept.
// R19: incomplete address or data byte aborts program and clears write latch.
// R20: busy bit zero of status reads one during programming.
// R21: host polls status instead of waiting worst-case time.
// R22: 20h, 52h, D8h erase 4 kB, 32 kB, 64 kB.
// R23: block erase starts at frame end, low address bits ignored per size.
// R24: host sets write latch before any block erase.
// R25: busy set during block erase; write latch cleared before it ends.
// R26: erase or program with write latch clear is ignored completely.
// R27: status stays readable while a self-timed operation runs.
//
`timescale 1ns/1ps
`default_nettype none
`include "fps_params.svh"

module fps_sequencer
   import fps_pkg::*;
#(
   parameter int unsigned ERASE_4K_CYCLES  = `FPS_BLOCK_ERASE_4K_TIME_US * `FPS_CLK_MHZ,
   parameter int unsigned ERASE_32K_CYCLES = `FPS_BLOCK_ERASE_32K_TIME_US * `FPS_CLK_MHZ,
   parameter int unsigned ERASE_64K_CYCLES = `FPS_BLOCK_ERASE_64K_TIME_US * `FPS_CLK_MHZ,
   parameter int unsigned CHIP_CYCLES      = `FPS_WHOLE_ARRAY_ERASE_US * `FPS_CLK_MHZ,
   parameter int unsigned PAGE_CYCLES      = `FPS_PAGE_PROGRAM_TIME_US * `FPS_CLK_MHZ
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        sck,
   input  wire logic        cs_n,
   input  wire logic        si,
   input  wire logic [2:0]  block_protect_field,
   input  wire logic        individual_lock_select,
   input  wire logic        any_block_locked,
   input  wire logic        erase_verify_fail,
   input  wire logic [7:0]  arr_rd_addr,
   output logic [7:0]       status_reg_one,
   output logic             erase_error_flag,
   output logic             program_error_flag,
   output logic             arr_erase,
   output logic [1:0]       arr_erase_size,
   output logic             arr_prog,
   output logic             arr_single,
   output logic [23:0]      arr_addr,
   output fps_byte_t        arr_rd_data,
   output logic             arr_rd_byte_en
);

   localparam logic [31:0] BYTE_CYCLES = 32'(`FPS_SINGLE_BYTE_PROG_US * `FPS_CLK_MHZ);

   // ----------------------------------------------------------------
   // reset release and pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] rst_pipe;
   logic       rst_n_sync;
   logic [8:0] sync_a;
   logic [8:0] sync_b;
   fps_byte_t  rx_byte;
   logic       rx_toggle;
   logic       mid_byte;

   assign rst_n_sync = rst_pipe[1];

   // reset asserts at once, releases two edges later
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rst_pipe <= 2'h0;
      else
         rst_pipe <= {rst_pipe[0], 1'b1};
   end

   // two flops on cs_n, the protect, lock and verify-fail pins, and the link toggle and mid_byte levels
   always_ff @(posedge clk or negedge rst_n_sync)
   begin
      if (!rst_n_sync)
      begin
         sync_a <= 9'h001;
         sync_b <= 9'h001;
      end
      else
      begin
         sync_a <= {rx_toggle, mid_byte, erase_verify_fail, any_block_locked,
                    individual_lock_select, block_protect_field, cs_n};
         sync_b <= sync_a;
      end
   end

   logic       cs_s;
   logic [2:0] bp_s;
   logic       wps_s;
   logic       lock_s;
   logic       fail_s;
   logic       mid_s;
   logic       tog_s;
   assign cs_s   = sync_b[0];
   assign bp_s   = sync_b[3:1];
   assign wps_s  = sync_b[4];
   assign lock_s = sync_b[5];
   assign fail_s = sync_b[6];
   assign mid_s  = sync_b[7];
   assign tog_s  = sync_b[8];

   // ----------------------------------------------------------------
   // link receiver and page buffer
   // ----------------------------------------------------------------
   logic       buf_wr;
   logic [7:0] wr_ptr;

   fps_link_rx u_rx (
      .sck        (sck),
      .cs_n       (cs_n),
      .si         (si),
      .rst_n_sync (rst_n_sync),
      .rx_byte    (rx_byte),
      .rx_toggle  (rx_toggle),
      .mid_byte   (mid_byte)
   );

   fps_page_buf u_buf (
      .clk     (clk),
      .wr_en   (buf_wr),
      .wr_addr (wr_ptr),
      .wr_data (rx_byte),
      .rd_addr (arr_rd_addr),
      .rd_data (arr_rd_data)
   );

   // ----------------------------------------------------------------
   // frame tracking and command decode
   // ----------------------------------------------------------------
   fps_state_e   state;
   fps_state_e   next_state;
   logic         cs_d;
   logic         tog_d;
   logic [2:0]   idx;
   logic [2:0]   next_idx;
   fps_byte_t    opcode;
   fps_byte_t    next_opcode;
   logic [23:0]  addr;
   logic [23:0]  next_addr;
   logic [7:0]   next_wr_ptr;
   logic [8:0]   data_cnt;
   logic [8:0]   next_data_cnt;
   logic [255:0] valid;
   logic [255:0] next_valid;
   logic         write_enable_latch;
   logic         next_wel;
   logic         busy;
   logic         next_busy;
   logic [31:0]  timer;
   logic [31:0]  next_timer;
   logic         next_arr_erase;
   logic [1:0]   next_arr_erase_size;
   logic         next_arr_prog;
   logic         next_arr_single;
   logic [23:0]  next_arr_addr;
   logic         next_ee;
   logic         next_pe;
   logic         byte_ev;
   logic         prot;
   logic         is_blk;
   logic         is_chip;

   assign byte_ev = tog_s ^ tog_d;
   // any protect bit or active lock protects all
   assign prot    = (bp_s != 3'h0) || (wps_s && lock_s);
   // R22: block erase opcodes
   assign is_blk  = (opcode == `FPS_OP_ERASE_4K) || (opcode == `FPS_OP_ERASE_32K) ||
                    (opcode == `FPS_OP_ERASE_64K);
   // R05: both chip erase opcodes
   assign is_chip = (opcode == `FPS_OP_CHIP_A) || (opcode == `FPS_OP_CHIP_B);

   // next frame, latch and timer values
   always_comb
   begin
      next_state          = state;
      next_idx            = idx;
      next_opcode         = opcode;
      next_addr           = addr;
      next_wr_ptr         = wr_ptr;
      next_data_cnt       = data_cnt;
      next_valid          = valid;
      next_wel            = write_enable_latch;
      next_busy           = busy;
      next_timer          = timer;
      next_arr_erase      = arr_erase;
      next_arr_erase_size = arr_erase_size;
      next_arr_prog       = arr_prog;
      next_arr_single     = arr_single;
      next_arr_addr       = arr_addr;
      next_ee             = erase_error_flag;
      next_pe             = program_error_flag;
      buf_wr              = 1'b0;
      unique case (state)
         FPS_IDLE:
         begin
            if (!cs_s && cs_d)
            begin
               next_state = FPS_FRAME;
               next_idx   = 3'h0;
            end
         end
         FPS_FRAME:
         begin
            if (byte_ev)
            begin
               // R11: opcode, address msb byte first, data
               if (idx == 3'h0)
                  next_opcode = rx_byte;
               else if (idx < `FPS_IDX_DATA)
                  next_addr = {addr[15:0], rx_byte};
               if (idx < `FPS_IDX_DATA)
                  next_idx = idx + 3'h1;
               if (idx == `FPS_IDX_DATA - 3'h1)
               begin
                  next_wr_ptr = rx_byte;
                  next_valid  = '0;
                  next_data_cnt = 9'h000;
               end
               // R17: pointer wraps inside the page; R18: later bytes overwrite
               if (idx == `FPS_IDX_DATA && opcode == `FPS_OP_PROGRAM && !busy && write_enable_latch)
               begin
                  buf_wr             = 1'b1;
                  next_valid[wr_ptr] = 1'b1;
                  next_wr_ptr        = wr_ptr + 8'h01;
                  if (data_cnt != `FPS_PAGE_BYTES)
                     next_data_cnt = data_cnt + 9'h001;
               end
            end
            if (cs_s && !cs_d)
               next_state = FPS_END;
         end
         FPS_END:
         begin
            next_state = FPS_IDLE;
            // R27: R10: while busy every frame is ignored, suspend included
            if (!busy && idx != 3'h0)
            begin
               if (opcode == `FPS_OP_WR_ENABLE && !mid_s)
                  next_wel = 1'b1;
               else if (opcode == `FPS_OP_WR_DISABLE && !mid_s)
                  next_wel = 1'b0;
               // R26: no latch, no effect
               else if ((is_blk || is_chip || opcode == `FPS_OP_PROGRAM) && write_enable_latch)
               begin
                  // R01: R15: R19: R02: cut off mid-byte or short address
                  if (mid_s || (!is_chip && idx < `FPS_IDX_DATA) ||
                      (opcode == `FPS_OP_PROGRAM && data_cnt == 9'h000))
                     next_wel = 1'b0;
                  // R03: R07: R16: protected target, drop and go idle
                  else if (prot)
                     next_wel = 1'b0;
                  else
                  begin
                     // R08: R13: R23: start at chip select release
                     next_busy = 1'b1;
                     next_ee   = 1'b0;
                     next_pe   = 1'b0;
                     if (opcode == `FPS_OP_PROGRAM)
                     begin
                        next_arr_prog   = 1'b1;
                        next_arr_single = (data_cnt == 9'h001);
                        next_arr_addr   = {addr[23:8], 8'h00};
                        // R13: shorter time for one byte
                        next_timer      = (data_cnt == 9'h001) ? BYTE_CYCLES : PAGE_CYCLES;
                     end
                     else
                     begin
                        next_arr_erase = 1'b1;
                        if (is_chip)
                        begin
                           next_arr_erase_size = `FPS_SIZE_CHIP;
                           next_arr_addr       = 24'h000000;
                           next_timer          = CHIP_CYCLES;
                        end
                        // R23: ignored low bits zeroed
                        else if (opcode == `FPS_OP_ERASE_4K)
                        begin
                           next_arr_erase_size = `FPS_SIZE_4K;
                           next_arr_addr       = {addr[23:12], 12'h000};
                           next_timer          = ERASE_4K_CYCLES;
                        end
                        else if (opcode == `FPS_OP_ERASE_32K)
                        begin
                           next_arr_erase_size = `FPS_SIZE_32K;
                           next_arr_addr       = {addr[23:15], 15'h0000};
                           next_timer          = ERASE_32K_CYCLES;
                        end
                        else
                        begin
                           next_arr_erase_size = `FPS_SIZE_64K;
                           next_arr_addr       = {addr[23:16], 16'h0000};
                           next_timer          = ERASE_64K_CYCLES;
                        end
                     end
                  end
               end
            end
         end
      endcase
      // R09: R25: latch falls on first busy cycle
      if (busy)
      begin
         next_wel = 1'b0;
         if (timer <= 32'h1)
         begin
            next_busy      = 1'b0;
            next_arr_erase = 1'b0;
            next_arr_prog  = 1'b0;
         end
         else
            next_timer = timer - 32'h1;
         // R04: verify failure raises both flags
         if (arr_erase && fail_s)
         begin
            next_ee = 1'b1;
            next_pe = 1'b1;
         end
      end
   end

   // decode and operation registers
   always_ff @(posedge clk or negedge rst_n_sync)
   begin
      if (!rst_n_sync)
      begin
         state              <= FPS_IDLE;
         cs_d               <= 1'b1;
         tog_d              <= 1'b0;
         idx                <= 3'h0;
         opcode             <= 8'h00;
         addr               <= 24'h000000;
         wr_ptr             <= 8'h00;
         data_cnt           <= 9'h000;
         valid              <= '0;
         write_enable_latch                <= 1'b0;
         busy               <= 1'b0;
         timer              <= 32'h0;
         arr_erase          <= 1'b0;
         arr_erase_size     <= `FPS_SIZE_4K;
         arr_prog           <= 1'b0;
         arr_single         <= 1'b0;
         arr_addr           <= 24'h000000;
         erase_error_flag   <= 1'b0;
         program_error_flag <= 1'b0;
         status_reg_one     <= `FPS_SR1_RESET;
         arr_rd_byte_en     <= 1'b0;
      end
      else
      begin
         state              <= next_state;
         cs_d               <= cs_s;
         tog_d              <= tog_s;
         idx                <= next_idx;
         opcode             <= next_opcode;
         addr               <= next_addr;
         wr_ptr             <= next_wr_ptr;
         data_cnt           <= next_data_cnt;
         valid              <= next_valid;
         write_enable_latch                <= next_wel;
         busy               <= next_busy;
         timer              <= next_timer;
         arr_erase          <= next_arr_erase;
         arr_erase_size     <= next_arr_erase_size;
         arr_prog           <= next_arr_prog;
         arr_single         <= next_arr_single;
         arr_addr           <= next_arr_addr;
         erase_error_flag   <= next_ee;
         program_error_flag <= next_pe;
         // R20: busy in bit zero, from next values
         status_reg_one     <= {3'h0, bp_s, next_wel, next_busy};
         // R12: unreceived bytes masked, left erased
         arr_rd_byte_en     <= valid[arr_rd_addr];
      end
   end

endmodule

`default_nettype wire

// ==== pkg/fps_params.svh ====
`ifndef FPS_PARAMS_SVH
`define FPS_PARAMS_SVH

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define FPS_OP_WR_ENABLE  8'h06
`define FPS_OP_WR_DISABLE 8'h04
`define FPS_OP_PROGRAM    8'h02
`define FPS_OP_ERASE_4K   8'h20
`define FPS_OP_ERASE_32K  8'h52
`define FPS_OP_ERASE_64K  8'hD8
`define FPS_OP_CHIP_A     8'h60
`define FPS_OP_CHIP_B     8'hC7
`define FPS_OP_SUSPEND    8'h75

// ----------------------------------------------------------------
// status_reg_one field positions and reset value
// ----------------------------------------------------------------
`define FPS_SR1_BUSY      0
`define FPS_SR1_WEL       1
`define FPS_SR1_BP_LO     2
`define FPS_SR1_BP_HI     4
`define FPS_SR1_RESET     8'h00

// ----------------------------------------------------------------
// frame layout: opcode byte, three address bytes, then data
// ----------------------------------------------------------------
`define FPS_IDX_ADDR      3'h1
`define FPS_IDX_DATA      3'h4
`define FPS_PAGE_BYTES    9'h100

// ----------------------------------------------------------------
// erase size codes on arr_erase_size
// ----------------------------------------------------------------
`define FPS_SIZE_4K       2'h0
`define FPS_SIZE_32K      2'h1
`define FPS_SIZE_64K      2'h2
`define FPS_SIZE_CHIP     2'h3

// ----------------------------------------------------------------
// self-timed durations in microseconds, clock rate in MHz
// ----------------------------------------------------------------
`define FPS_CLK_MHZ                 20
`define FPS_BLOCK_ERASE_4K_TIME_US  50000
`define FPS_BLOCK_ERASE_32K_TIME_US 150000
`define FPS_BLOCK_ERASE_64K_TIME_US 250000
`define FPS_WHOLE_ARRAY_ERASE_US    4000000
`define FPS_PAGE_PROGRAM_TIME_US    2000
`define FPS_SINGLE_BYTE_PROG_US     30

`endif

// ==== pkg/fps_pkg.sv ====
package fps_pkg;

   // frame tracking states
   typedef enum logic [1:0] {
      FPS_IDLE,
      FPS_FRAME,
      FPS_END
   } fps_state_e;

   typedef logic [7:0] fps_byte_t;

endpackage

// ==== hdl/fps_link_rx.sv ====
`timescale 1ns/1ps
`default_nettype none

// sck domain: bytes in, msb first
module fps_link_rx
   import fps_pkg::*;
(
   input  wire logic      sck,
   input  wire logic      cs_n,
   input  wire logic      si,
   input  wire logic      rst_n_sync,
   output fps_byte_t      rx_byte,
   output logic           rx_toggle,
   output logic           mid_byte
);

   logic [2:0] bit_cnt;
   logic [2:0] next_bit_cnt;
   fps_byte_t  shift;
   fps_byte_t  next_shift;
   fps_byte_t  next_rx_byte;
   logic       next_rx_toggle;
   logic       next_mid_byte;

   // ----------------------------------------------------------------
   // bit counting and byte capture
   // ----------------------------------------------------------------
   // byte holds eight sck periods, enough for the toggle crossing
   always_comb
   begin
      next_bit_cnt   = bit_cnt + 3'h1;
      next_shift     = {shift[6:0], si};
      next_rx_byte   = rx_byte;
      next_rx_toggle = rx_toggle;
      if (bit_cnt == 3'h7)
      begin
         next_rx_byte   = {shift[6:0], si};
         next_rx_toggle = ~rx_toggle;
      end
      next_mid_byte  = (next_bit_cnt != 3'h0);
   end

   // chip select high holds the counter at zero
   always_ff @(posedge sck or posedge cs_n)
   begin
      if (cs_n)
         bit_cnt <= 3'h0;
      else
         bit_cnt <= next_bit_cnt;
   end

   // mid_byte survives frame end to judge the cut
   always_ff @(posedge sck or negedge rst_n_sync)
   begin
      if (!rst_n_sync)
      begin
         shift     <= 8'h00;
         rx_byte   <= 8'h00;
         rx_toggle <= 1'b0;
         mid_byte  <= 1'b0;
      end
      else
      begin
         shift     <= next_shift;
         rx_byte   <= next_rx_byte;
         rx_toggle <= next_rx_toggle;
         mid_byte  <= next_mid_byte;
      end
   end

endmodule

`default_nettype wire

// ==== hdl/fps_page_buf.sv ====
`timescale 1ns/1ps
`default_nettype none

// one page of program data, registered read
module fps_page_buf
   import fps_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_addr,
   input  wire fps_byte_t  wr_data,
   input  wire logic [7:0] rd_addr,
   output fps_byte_t       rd_data
);

   fps_byte_t mem [0:255];

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   // no reset: unwritten entries are masked
   always_ff @(posedge clk)
   begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
      rd_data <= mem[rd_addr];
   end

endmodule

`default_nettype wire

// ==== sim/fps_sequencer_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// start and status rules at the ports
module fps_sequencer_sva
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        cs_n,
   input wire logic        individual_lock_select,
   input wire logic        any_block_locked,
   input wire logic [7:0]  status_reg_one,
   input wire logic        erase_error_flag,
   input wire logic        program_error_flag,
   input wire logic        arr_erase,
   input wire logic [1:0]  arr_erase_size,
   input wire logic        arr_prog,
   input wire logic [23:0] arr_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // array busy and full lock
   wire logic op_go = arr_prog | arr_erase;
   wire logic lock_on = individual_lock_select & any_block_locked;
   property p_busy_on; $rose(op_go) |-> ##[0:1] status_reg_one[0]; endproperty
   a_busy_on: assert property (p_busy_on)
      else $error("busy missing");
   property p_wel_drop; $rose(op_go) |-> ##[0:2] !status_reg_one[1]; endproperty
   a_wel_drop: assert property (p_wel_drop)
      else $error("latch kept");
   property p_wel_needed; $rose(op_go) |-> $past(status_reg_one[1]); endproperty
   a_wel_needed: assert property (p_wel_needed)
      else $error("start without latch");
   property p_after_frame; $rose(op_go) |-> cs_n && $past(cs_n, 2); endproperty
   a_after_frame: assert property (p_after_frame)
      else $error("start in frame");
   property p_unprot; $rose(op_go) |-> status_reg_one[4:2] == 3'h0 && !$past(lock_on, 4); endproperty
   a_unprot: assert property (p_unprot)
      else $error("start when protected");
   property p_page_base; arr_prog |-> arr_addr[7:0] == 8'h00 && !arr_erase; endproperty
   a_page_base: assert property (p_page_base)
      else $error("page base");
   property p_erase_base; arr_erase && arr_erase_size != 2'h3 |-> arr_addr[11:0] == 12'h000; endproperty
   a_erase_base: assert property (p_erase_base)
      else $error("erase base");
   property p_err_pair; erase_error_flag |-> program_error_flag; endproperty
   a_err_pair: assert property (p_err_pair)
      else $error("error pair");
endmodule
bind fps_sequencer fps_sequencer_sva fps_sequencer_sva_i (.clk, .rst_n, .cs_n, .individual_lock_select,
   .any_block_locked, .status_reg_one, .erase_error_flag, .program_error_flag, .arr_erase,
   .arr_erase_size, .arr_prog, .arr_addr);
`default_nettype wire

// ==== sim/fps_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// spi host, mode 0, idle clock low
module fps_host_model
(
   output logic sck,
   output logic cs_n,
   output logic si
);
   localparam time HALF = 15ns;
   initial
   begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end
   task automatic frame(input logic [7:0] q[$], input int xb);
      int i;
      cs_n = 1'b0;
      #(HALF * (1 + $urandom_range(3)));
      for (i = 0; i < q.size() * 8 + xb; i++)
      begin
         si = (i < q.size() * 8) ? q[i / 8][7 - i % 8] : 1'($urandom);
         #HALF sck = 1'b1;
         #HALF sck = 1'b0;
      end
      #(HALF * 7) cs_n = 1'b1;
      // line does not keep last bit
      si = ~si;
   endtask
endmodule
`default_nettype wire

// ==== sim/fps_sequencer_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module fps_sequencer_bench;
   localparam int PG = 300;
   localparam int ER = 50;
   logic        clk, rst_n, individual_lock_select, any_block_locked, erase_verify_fail;
   wire logic   sck, cs_n, si;
   logic [2:0]  block_protect_field;
   logic [7:0]  arr_rd_addr, status_reg_one, arr_rd_data;
   logic        erase_error_flag, program_error_flag, arr_erase, arr_prog, arr_single, arr_rd_byte_en;
   logic [1:0]  arr_erase_size;
   logic [23:0] arr_addr;
   int          err_count = 0, total_checks = 0, cyc = 0, run_len = 0, last_dur = 0;
   int          pg [256];
   fps_host_model fps_host_model_i (.sck, .cs_n, .si);
   fps_sequencer #(.ERASE_4K_CYCLES(ER), .ERASE_32K_CYCLES(ER), .ERASE_64K_CYCLES(ER), .CHIP_CYCLES(ER),
      .PAGE_CYCLES(PG)) fps_sequencer_i (.clk, .rst_n, .sck, .cs_n, .si, .block_protect_field,
      .individual_lock_select, .any_block_locked, .erase_verify_fail, .arr_rd_addr, .status_reg_one,
      .erase_error_flag, .program_error_flag, .arr_erase, .arr_erase_size, .arr_prog, .arr_single,
      .arr_addr, .arr_rd_data, .arr_rd_byte_en);
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // busy length, hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (arr_prog | arr_erase)
         run_len <= run_len + 1;
      else if (run_len != 0)
      begin
         last_dur <= run_len;
         run_len <= 0;
      end
      if (cyc == 30000)
      begin
         err_count++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d fails %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // one frame and its outcome
   task automatic run(input logic [7:0] q[$], input int xb, input bit go, input logic [23:0] ea = 0,
      input logic [1:0] es = 0, input int dur = 0);
      int i;
      bit seen;
      fps_host_model_i.frame(q, xb);
      seen = 1'b0;
      for (i = 0; i < 12 && !seen; i++)
      begin
         @(negedge clk);
         seen = ((arr_prog | arr_erase) === 1'b1);
      end
      chk(seen, go);
      if (seen)
      begin
         repeat (2) @(negedge clk);
         chk(status_reg_one[1:0], 2'h1);
         if (es != 2'h3)
            chk(arr_addr, ea);
         chk(arr_prog ? {1'b0, arr_single} : arr_erase_size, es);
         for (i = 0; i < 256 && arr_prog; i++)
         begin
            arr_rd_addr = i[7:0];
            @(negedge clk);
            chk(arr_rd_byte_en, pg[i] >= 0);
            if (pg[i] >= 0)
               chk(arr_rd_data, pg[i]);
         end
         for (i = 0; i < 1000 && (arr_prog | arr_erase) !== 1'b0; i++)
            @(negedge clk);
         repeat (2) @(negedge clk);
         chk(last_dur >= dur - 1 && last_dur <= dur + 2, 1'b1);
      end
      repeat (8) @(negedge clk);
      chk(status_reg_one[1], 1'b0);
      $display("done %0t", $time);
   endtask
   task automatic we();
      fps_host_model_i.frame({8'h06}, 0);
      repeat (8) @(negedge clk);
      chk(status_reg_one[1], 1'b1);
   endtask
   // program frame, page image
   task automatic prog(input logic [23:0] a, input int n, input bit go);
      logic [7:0] q[$];
      int k;
      q = {8'h02, a[23:16], a[15:8], a[7:0]};
      for (k = 0; k < 256; k++)
         pg[k] = -1;
      for (k = 0; k < n; k++)
      begin
         q.push_back(8'($urandom));
         pg[(a[7:0] + k) % 256] = q[k + 4];
      end
      run(q, 0, go, {a[23:8], 8'h00}, {1'b0, n == 1}, n == 1 ? 600 : PG);
   endtask
   initial
   begin
      logic [7:0] ops [3] = '{8'h20, 8'h52, 8'hD8};
      logic [23:0] msk [3] = '{24'hFFF000, 24'hFF8000, 24'hFF0000};
      logic [23:0] ra;
      int i;
      rst_n = 1'b0;
      {individual_lock_select, any_block_locked, erase_verify_fail} = 3'h0;
      block_protect_field = 3'h0;
      arr_rd_addr = 8'h00;
      void'($urandom(32'h601A));
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      ra = 24'($urandom);
      prog(ra, 3, 0);
      we(); prog({ra[23:8], 8'hFE}, 3, 1);
      we(); prog(ra, 1, 1);
      we(); prog(ra, 300, 1);
      we(); run({8'h02, ra[23:16], ra[15:8], ra[7:0], 8'h5A}, 3, 0);
      we(); run({8'h02, ra[23:16], ra[15:8]}, 0, 0);
      we(); run({8'hD8, ra[23:16], ra[15:8], ra[7:0]}, 5, 0);
      we(); run({8'h52, ra[23:16]}, 0, 0);
      we(); run({8'h60}, 7, 0);
      for (i = 0; i < 3; i++)
      begin
         we();
         ra = 24'($urandom);
         run({ops[i], ra[23:16], ra[15:8], ra[7:0]}, 0, 1, ra & msk[i], i[1:0], ER);
      end
      chk({erase_error_flag, program_error_flag}, 2'h0);
      we(); run({8'h60}, 0, 1, 24'h0, 2'h3, ER);
      we();
      fork
         run({8'hC7}, 0, 1, 24'h0, 2'h3, ER);
         begin
            repeat (24) @(negedge clk);
            fps_host_model_i.frame({8'h75}, 0);
         end
      join
      block_protect_field = 3'($urandom_range(7, 1));
      we(); run({8'hD8, ra[23:16], ra[15:8], ra[7:0]}, 0, 0);
      block_protect_field = 3'h0;
      {individual_lock_select, any_block_locked} = 2'h3;
      we(); run({8'h60}, 0, 0);
      we(); prog(ra, 2, 0);
      {individual_lock_select, any_block_locked} = 2'($urandom_range(2));
      erase_verify_fail = 1'b1;
      we(); run({8'h20, 8'h00, 8'h10, 8'h00}, 0, 1, 24'h001000, 2'h0, ER);
      chk({erase_error_flag, program_error_flag}, 2'h3);
      erase_verify_fail = 1'b0;
      tally_and_finish();
   end
endmodule
`default_nettype wire
